// File: simd_check_defines.svh
// Offsets, field positions, reset values, legacy limit and alignment mask of the exception checker
`ifndef SIMD_CHECK_DEFINES_SVH
`define SIMD_CHECK_DEFINES_SVH

`define OFS_CTRL_ZERO 8'h00
`define OFS_CTRL_FOUR 8'h04
`define OFS_STATUS 8'h08
`define OFS_MASK 8'h0c
`define OFS_RESULT 8'h10

`define BIT_COPROC_ABSENT 2
`define BIT_TASK_SWITCHED 3
`define BIT_OS_EXT_STATE 9
`define BIT_OS_SIMD_FAULT 10

`define RST_CTRL_ZERO 32'h0000_0000
`define RST_CTRL_FOUR 32'h0000_0000
`define RST_STATUS 16'h0000
`define RST_MASK 16'h0000

`define LEGACY_LIMIT 33'h0_0000_ffff
`define WIDE_ALIGN_MASK 32'h0000_000f

`endif

// File: simd_check_pkg.sv
// Types shared by the exception checker and its users
package simd_check_pkg;

    typedef enum logic [1:0] {
        MODE_REAL = 2'b00,
        MODE_V86 = 2'b01,
        MODE_PROT = 2'b10,
        MODE_LONG = 2'b11
    } cpu_mode_e;

    typedef enum logic [1:0] {
        CLS_FP_ALIGN = 2'b00,
        CLS_XMM_FP = 2'b01,
        CLS_XMM_NOFP = 2'b10
    } insn_class_e;

    typedef enum logic [3:0] {
        EXC_NONE = 4'b0000,
        EXC_PRIOR_TRAP = 4'b0001,
        EXC_EXT_INTR = 4'b0010,
        EXC_FETCH = 4'b0011,
        EXC_INVALID_OPCODE = 4'b0100,
        EXC_DEVICE_UNAVAIL = 4'b0101,
        EXC_X87_PENDING = 4'b0110,
        EXC_STACK = 4'b0111,
        EXC_GEN_PROT = 4'b1000,
        EXC_PAGE = 4'b1001,
        EXC_ALIGN_CHECK = 4'b1010,
        EXC_SIMD_FLOAT = 4'b1011
    } exc_kind_e;

    typedef struct packed {
        logic wb_ack;
        logic [31:0] wb_rdata;
        logic [31:0] ctrl_zero;
        logic [31:0] ctrl_four;
        logic [15:0] status;
        logic [15:0] mask;
        logic res_valid;
        exc_kind_e res_kind;
        logic [31:0] res_code;
    } check_state_s;

endpackage

// File: simd_exception_check.sv
// Exception checker for legacy SIMD instructions on the multimedia registers
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "simd_check_defines.svh"

module simd_exception_check
    import simd_check_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Wishbone register slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [ADDR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // Category sources ahead of execution
    input wire logic prior_trap,
    input wire logic ext_intr,
    input wire logic fetch_fault,
    // Check request from decode and execute
    input wire logic chk_valid,
    input wire logic [1:0] chk_mode,
    input wire logic [1:0] chk_class,
    input wire logic chk_lock_prefix,
    input wire logic chk_features_ok,
    input wire logic chk_x87_pending,
    input wire logic chk_simd_unmasked,
    input wire logic [1:0] chk_cpl,
    input wire logic chk_align_enabled,
    // Memory operand properties
    input wire logic mem_present,
    input wire logic [31:0] mem_addr,
    input wire logic [4:0] mem_size,
    input wire logic mem_ss_ref,
    input wire logic mem_seg_illegal,
    input wire logic mem_noncanonical,
    input wire logic xlate_fail,
    input wire logic [31:0] xlate_code,
    // Result
    output logic exc_valid,
    output exc_kind_e exc_kind,
    output logic [31:0] exc_error_code,
    // Interrupt
    output logic irq
);

    // ****************************************
    // Helpers
    // ****************************************

    // Byte-lane merge for register writes
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    // True when the address is not a multiple of the operand size
    function automatic logic misaligned(
        input logic [31:0] addr,
        input logic [4:0] size
    );
        logic [31:0] lowmask;
        lowmask = {27'h0, size} - 32'h0000_0001;
        return (size != 5'h00) && ((addr & lowmask) != 32'h0000_0000);
    endfunction

    // One-hot status bit for an exception kind
    function automatic logic [15:0] kind_bit(input exc_kind_e k);
        logic [15:0] b;
        b = 16'h0000;
        if (k != EXC_NONE)
        begin
            b[k] = 1'b1;
        end
        return b;
    endfunction

    // ****************************************
    // State
    // ****************************************

    check_state_s s_q;
    check_state_s s_d;

    // ****************************************
    // Condition decode
    // ****************************************

    cpu_mode_e mode;
    insn_class_e cls;
    logic has_fp;
    logic coproc_absent;
    logic task_switched;
    logic ext_state_ok;
    logic simd_fault_ok;
    logic [32:0] last_byte;
    logic undef_hit;
    logic unavail_hit;
    logic x87_hit;
    logic ss_hit;
    logic prot_hit;
    logic page_hit;
    logic align_hit;
    logic simd_hit;
    exc_kind_e pick;
    logic [31:0] pick_code;

    always_comb
    begin
        mode = cpu_mode_e'(chk_mode);
        cls = insn_class_e'(chk_class);
        coproc_absent = s_q.ctrl_zero[`BIT_COPROC_ABSENT];
        task_switched = s_q.ctrl_zero[`BIT_TASK_SWITCHED];
        ext_state_ok = s_q.ctrl_four[`BIT_OS_EXT_STATE];
        simd_fault_ok = s_q.ctrl_four[`BIT_OS_SIMD_FAULT];
        // The class without float exceptions ignores the unmasked SIMD float fault; the x87 pending check still applies to it
        has_fp = (cls != CLS_XMM_NOFP);
        last_byte = {1'b0, mem_addr} + {28'h0, mem_size} - 33'h0_0000_0001;

        undef_hit = coproc_absent
            || !ext_state_ok
            || chk_lock_prefix
            || !chk_features_ok
            || (has_fp && chk_simd_unmasked && !simd_fault_ok);
        unavail_hit = task_switched;
        x87_hit = chk_x87_pending;

        ss_hit = 1'b0;
        prot_hit = 1'b0;
        page_hit = 1'b0;
        align_hit = 1'b0;
        if (mem_present)
        begin
            unique case (mode)
                MODE_PROT:
                begin
                    ss_hit = mem_ss_ref && mem_seg_illegal;
                    prot_hit = !mem_ss_ref && mem_seg_illegal;
                end
                MODE_LONG:
                begin
                    ss_hit = mem_ss_ref && mem_noncanonical;
                    prot_hit = !mem_ss_ref && mem_noncanonical;
                end
                MODE_REAL, MODE_V86:
                begin
                    prot_hit = (last_byte > `LEGACY_LIMIT);
                end
            endcase
            if (cls == CLS_FP_ALIGN && (mem_addr & `WIDE_ALIGN_MASK) != 32'h0000_0000)
            begin
                prot_hit = 1'b1;
            end
            page_hit = (mode != MODE_REAL) && xlate_fail;
            align_hit = (cls != CLS_FP_ALIGN) && (mode != MODE_REAL) && chk_align_enabled
                && (chk_cpl == 2'b11) && misaligned(mem_addr, mem_size);
        end
        simd_hit = has_fp && chk_simd_unmasked && simd_fault_ok;

        // Categories strictly by rank, then a fixed order inside execution
        pick = EXC_NONE;
        pick_code = 32'h0000_0000;
        if (prior_trap)
        begin
            pick = EXC_PRIOR_TRAP;
        end
        else if (ext_intr)
        begin
            pick = EXC_EXT_INTR;
        end
        else if (fetch_fault)
        begin
            pick = EXC_FETCH;
        end
        else if (chk_valid)
        begin
            if (undef_hit)
            begin
                pick = EXC_INVALID_OPCODE;
            end
            else if (unavail_hit)
            begin
                pick = EXC_DEVICE_UNAVAIL;
            end
            else if (x87_hit)
            begin
                pick = EXC_X87_PENDING;
            end
            else if (ss_hit)
            begin
                pick = EXC_STACK;
            end
            else if (prot_hit)
            begin
                pick = EXC_GEN_PROT;
            end
            else if (page_hit)
            begin
                pick = EXC_PAGE;
                pick_code = xlate_code;
            end
            else if (align_hit)
            begin
                pick = EXC_ALIGN_CHECK;
            end
            else if (simd_hit)
            begin
                pick = EXC_SIMD_FLOAT;
            end
        end
    end

    // ****************************************
    // Next state
    // ****************************************

    logic bus_req;
    logic bus_wr;
    logic [15:0] clr_bits;
    logic [15:0] set_bits;
    logic [31:0] clr_wide;
    logic [31:0] mask_wide;

    always_comb
    begin
        s_d = s_q;
        clr_wide = lane_merge(32'h0000_0000, wb_dat_w, wb_sel);
        mask_wide = lane_merge({16'h0000, s_q.mask}, wb_dat_w, wb_sel);
        bus_req = wb_cyc && wb_stb && !s_q.wb_ack;
        bus_wr = bus_req && wb_we;
        clr_bits = 16'h0000;
        set_bits = kind_bit(pick);

        // Single-wait slave: ack one cycle after the strobe, dropped next cycle
        s_d.wb_ack = bus_req;
        if (bus_req && !wb_we)
        begin
            unique case (wb_adr)
                `OFS_CTRL_ZERO: s_d.wb_rdata = s_q.ctrl_zero;
                `OFS_CTRL_FOUR: s_d.wb_rdata = s_q.ctrl_four;
                `OFS_STATUS: s_d.wb_rdata = {16'h0000, s_q.status};
                `OFS_MASK: s_d.wb_rdata = {16'h0000, s_q.mask};
                `OFS_RESULT: s_d.wb_rdata = {s_q.res_code[23:0], 3'b000, s_q.res_valid, s_q.res_kind};
                default: s_d.wb_rdata = 32'h0000_0000;
            endcase
        end
        if (bus_wr)
        begin
            unique case (wb_adr)
                `OFS_CTRL_ZERO: s_d.ctrl_zero = lane_merge(s_q.ctrl_zero, wb_dat_w, wb_sel);
                `OFS_CTRL_FOUR: s_d.ctrl_four = lane_merge(s_q.ctrl_four, wb_dat_w, wb_sel);
                `OFS_STATUS: clr_bits = clr_wide[15:0];
                `OFS_MASK: s_d.mask = mask_wide[15:0];
                default:
                begin
                end
            endcase
        end

        // A new event wins over a write-one clear in the same cycle
        s_d.status = (s_q.status & ~clr_bits) | set_bits;

        s_d.res_valid = (pick != EXC_NONE);
        if (pick != EXC_NONE)
        begin
            s_d.res_kind = pick;
            s_d.res_code = pick_code;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_q.wb_ack <= 1'b0;
            s_q.wb_rdata <= 32'h0000_0000;
            s_q.ctrl_zero <= `RST_CTRL_ZERO;
            s_q.ctrl_four <= `RST_CTRL_FOUR;
            s_q.status <= `RST_STATUS;
            s_q.mask <= `RST_MASK;
            s_q.res_valid <= 1'b0;
            s_q.res_kind <= EXC_NONE;
            s_q.res_code <= 32'h0000_0000;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************

    assign wb_ack = s_q.wb_ack;
    assign wb_dat_r = s_q.wb_rdata;
    assign exc_valid = s_q.res_valid;
    assign exc_kind = s_q.res_kind;
    assign exc_error_code = s_q.res_code;
    assign irq = |(s_q.status & s_q.mask);

endmodule // simd_exception_check

// File: exc_check_sva.sv
// Port-level checks of the SIMD exception checker
`timescale 1ns/100ps

module exc_check_sva
    import simd_check_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Requests
    input wire logic prior_trap,
    input wire logic ext_intr,
    input wire logic fetch_fault,
    input wire logic chk_valid,
    input wire logic [1:0] chk_class,
    input wire logic chk_lock_prefix,
    input wire logic chk_features_ok,
    input wire logic [31:0] xlate_code,
    // Results
    input wire logic exc_valid,
    input wire exc_kind_e exc_kind,
    input wire logic [31:0] exc_error_code
);
    logic cat;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    assign cat = prior_trap || ext_intr || fetch_fault;

    // **********
    // Checks
    // **********
    property p_trap; prior_trap |=> exc_valid && exc_kind == EXC_PRIOR_TRAP; endproperty
    a_trap: assert property (p_trap) else $error("trap not first");
    property p_intr; ext_intr && !prior_trap |=> exc_valid && exc_kind == EXC_EXT_INTR; endproperty
    a_intr: assert property (p_intr) else $error("interrupt not second");
    property p_idle; !chk_valid && !cat |=> !exc_valid; endproperty
    a_idle: assert property (p_idle) else $error("result without source");
    property p_lock; chk_valid && chk_lock_prefix && !cat |=> exc_kind == EXC_INVALID_OPCODE; endproperty
    a_lock: assert property (p_lock) else $error("lock prefix accepted");
    property p_feat; chk_valid && !chk_features_ok && !cat |=> exc_kind == EXC_INVALID_OPCODE; endproperty
    a_feat: assert property (p_feat) else $error("missing feature accepted");
    property p_page; exc_valid && exc_kind == EXC_PAGE |-> exc_error_code == $past(xlate_code); endproperty
    a_page: assert property (p_page) else $error("page fault code wrong");
    property p_zero; exc_valid && exc_kind != EXC_PAGE |-> exc_error_code == 32'h0; endproperty
    a_zero: assert property (p_zero) else $error("error code not zero");
    property p_nofp; chk_valid && chk_class == 2'h2 |=> !(exc_valid && exc_kind == EXC_SIMD_FLOAT); endproperty
    a_nofp: assert property (p_nofp) else $error("float fault on class without float");

    c_page: cover property (exc_valid && exc_kind == EXC_PAGE);
    c_float: cover property (exc_valid && exc_kind == EXC_SIMD_FLOAT);
    c_trap: cover property (exc_valid && exc_kind == EXC_PRIOR_TRAP);

endmodule // exc_check_sva

// File: pipe_model.sv
// Pipeline model that issues check requests to the exception checker
`timescale 1ns/100ps

module pipe_model
(
    // Clock
    input wire logic clk,
    // Category sources
    output logic prior_trap,
    output logic ext_intr,
    output logic fetch_fault,
    // Check request
    output logic chk_valid,
    output logic [1:0] chk_mode,
    output logic [1:0] chk_class,
    output logic chk_lock_prefix,
    output logic chk_features_ok,
    output logic chk_x87_pending,
    output logic chk_simd_unmasked,
    output logic [1:0] chk_cpl,
    output logic chk_align_enabled,
    // Memory operand
    output logic mem_present,
    output logic [31:0] mem_addr,
    output logic [4:0] mem_size,
    output logic mem_ss_ref,
    output logic mem_seg_illegal,
    output logic mem_noncanonical,
    output logic xlate_fail,
    output logic [31:0] xlate_code
);
    logic [8:0] fl;

    assign {xlate_fail, mem_noncanonical, mem_seg_illegal, mem_ss_ref, chk_align_enabled} = fl[8:4];
    assign {chk_simd_unmasked, chk_x87_pending, chk_features_ok, chk_lock_prefix} = fl[3:0] ^ 4'h2;

    initial
    begin
        fl = 9'h0;
        {prior_trap, ext_intr, fetch_fault, chk_valid, mem_present} = 5'h0;
        {chk_mode, chk_class, chk_cpl, mem_addr, mem_size, xlate_code} = '0;
    end

    // **********
    // Request issue
    // **********
    // Idle flags, address and translation code show inverted values so stale ones cannot pass for a request
    task automatic issue(input logic [1:0] m, c, input logic [12:0] f, input logic [31:0] a, input logic [4:0] s);
        @(posedge clk);
        {fetch_fault, ext_intr, prior_trap, chk_valid, mem_present} <= {f[12:10], 2'b11};
        chk_mode <= m;
        chk_class <= c;
        chk_cpl <= f[9] ? 2'h0 : 2'h3;
        fl <= f[8:0];
        mem_addr <= a;
        mem_size <= s;
        xlate_code <= ~a;
        @(posedge clk);
        {fetch_fault, ext_intr, prior_trap, chk_valid, mem_present} <= 5'h0;
        fl <= ~f[8:0];
        mem_addr <= ~a;
        xlate_code <= a;
    endtask

endmodule // pipe_model

// File: legacy_simd_exception_check_bench.sv
// Self-checking bench for the SIMD exception checker
`timescale 1ns/100ps

`define CHK(a, b) \
    total_checks++; \
    if ((a) !== (b)) \
    begin \
        num_errors++; \
        $display("wrong value at %0t: %h expected %h", $time, (a), (b)); \
    end

module legacy_simd_exception_check_bench
    import simd_check_pkg::*;
    ;
    logic clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, exc_valid, irq, xlate_fail;
    logic prior_trap, ext_intr, fetch_fault, chk_valid, chk_lock_prefix, chk_features_ok, chk_x87_pending;
    logic chk_simd_unmasked, chk_align_enabled, mem_present, mem_ss_ref, mem_seg_illegal, mem_noncanonical;
    logic [1:0] chk_mode, chk_class, chk_cpl;
    logic [3:0] wb_sel;
    logic [4:0] mem_size;
    logic [7:0] wb_adr;
    logic [31:0] wb_dat_w, wb_dat_r, exc_error_code, mem_addr, xlate_code, rdat;
    exc_kind_e exc_kind;
    int num_errors, total_checks;

    simd_exception_check dut (.*);
    pipe_model pm (.*);

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // **********
    // Tasks
    // **********
    task automatic test_done;
        if (num_errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_w <= d;
        do
            @(posedge clk);
        while (wb_ack !== 1'b1 && ++n < 9);
        `CHK(wb_ack, 1'b1)
        rdat = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] e);
        wb(1'b0, adr, 32'h0);
        `CHK(rdat, e)
    endtask

    task automatic t(input logic [12:0] f, input logic [1:0] m, c, input exc_kind_e k,
        input logic [31:0] a = 32'h100, input logic [4:0] s = 5'h8);
        pm.issue(m, c, f, a, s);
        #1;
        `CHK(exc_valid, k != EXC_NONE)
        if (k != EXC_NONE)
        begin
            `CHK(exc_kind, k)
            `CHK(exc_error_code, k == EXC_PAGE ? ~a : 32'h0)
        end
    endtask

    initial
    begin
        repeat (4000) @(posedge clk);
        num_errors++;
        test_done;
    end

    // **********
    // Tests
    // **********
    initial
    begin
        {rst_n, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} = '0;
        wb_sel = 4'hf;
        num_errors = 0;
        total_checks = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h04, 32'h0);
        rd(8'h20, 32'h0);
        t(13'h0, 2'h2, 2'h1, EXC_INVALID_OPCODE);
        wb(1'b1, 8'h04, 32'h600);
        t(13'h1, 2'h2, 2'h1, EXC_INVALID_OPCODE);
        t(13'h2, 2'h2, 2'h1, EXC_INVALID_OPCODE);
        t(13'h4, 2'h2, 2'h1, EXC_X87_PENDING);
        wb(1'b1, 8'h00, 32'h8);
        t(13'h4, 2'h2, 2'h1, EXC_DEVICE_UNAVAIL);
        wb(1'b1, 8'h00, 32'h4);
        t(13'h0, 2'h0, 2'h1, EXC_INVALID_OPCODE);
        wb(1'b1, 8'h00, 32'h0);
        t(13'h8, 2'h3, 2'h1, EXC_SIMD_FLOAT);
        t(13'h8, 2'h3, 2'h2, EXC_NONE);
        wb(1'b1, 8'h04, 32'h200);
        t(13'h8, 2'h1, 2'h1, EXC_INVALID_OPCODE);
        t(13'h8, 2'h1, 2'h2, EXC_NONE);
        wb(1'b1, 8'h04, 32'h600);
        t(13'h60, 2'h2, 2'h1, EXC_STACK);
        t(13'h140, 2'h2, 2'h1, EXC_GEN_PROT);
        t(13'ha0, 2'h3, 2'h1, EXC_STACK);
        t(13'h80, 2'h3, 2'h1, EXC_GEN_PROT);
        t(13'h0, 2'h1, 2'h1, EXC_GEN_PROT, 32'hfff9);
        t(13'h0, 2'h0, 2'h1, EXC_NONE, 32'hfff8);
        t(13'h0, 2'h0, 2'h0, EXC_GEN_PROT, 32'h108, 5'h10);
        t(13'h10, 2'h2, 2'h1, EXC_ALIGN_CHECK, 32'h104);
        t(13'h210, 2'h2, 2'h2, EXC_NONE, 32'h104);
        t(13'h100, 2'h1, 2'h1, EXC_PAGE);
        t(13'h1c01, 2'h2, 2'h1, EXC_PRIOR_TRAP);
        t(13'h1801, 2'h2, 2'h1, EXC_EXT_INTR);
        t(13'h1001, 2'h2, 2'h1, EXC_FETCH);
        rd(8'h10, 32'h3);
        rd(8'h08, 32'hffe);
        wb(1'b1, 8'h0c, 32'h2);
        #1;
        `CHK(irq, 1'b1)
        wb(1'b1, 8'h08, 32'h2);
        rd(8'h08, 32'hffc);
        #1;
        `CHK(irq, 1'b0)
        test_done;
    end

endmodule // legacy_simd_exception_check_bench

bind simd_exception_check exc_check_sva sva (.*);
